//--- ssw_cpu_model.sv
/*
  Supervised processor: toggles the kick every i_gap cycles while running.
  Assumes the bench sets i_gap of at least 1.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_cpu_model (
  // Clock and supervised reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_low,
  // Bench control
  input  wire logic       i_run,
  input  wire logic [7:0] i_gap,
  // Kick line
  output logic            o_kick
);
  logic [7:0] cnt_r;

  initial o_kick = 1'b0;

  // A processor held in reset cannot kick
  always @(posedge i_clk) begin
    if (!i_run || !i_rst_low) begin
      cnt_r <= 8'h00;
    end else if (cnt_r + 8'h01 >= i_gap) begin
      cnt_r  <= 8'h00;
      o_kick <= !o_kick;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // ssw_cpu_model

`default_nettype wire

//--- ssw_kick_edge.sv
/*
  Transition detector on the watchdog kick input.
  Assumes the kick is already synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_kick_edge (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Kick level and transition flag
  input  wire logic i_kick,
  output logic      o_edge
);

  logic prev_r;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= i_kick;
    end
  end

  // Either direction counts
  assign o_edge = i_kick ^ prev_r;

endmodule // ssw_kick_edge

`default_nettype wire

//--- ssw_pkg.sv
/*
  Shared constants and types for the supply supervisor with watchdog.
  Assumes a single 40 MHz clock; every time is counted in cycles of it.
*/
`default_nettype none

package ssw_pkg;

  // Clock rate and cycles per millisecond
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;

  // Counter width, enough for the longest watchdog period (960e6 cycles)
  localparam int unsigned CNT_W        = 30;

  // Watchdog expiry time options, in milliseconds
  localparam int unsigned WDT_MS_0     = 3300;
  localparam int unsigned WDT_MS_1     = 6000;
  localparam int unsigned WDT_MS_2     = 12000;
  localparam int unsigned WDT_MS_3     = 24000;

  // Reset hold time range, in milliseconds
  localparam int unsigned HOLD_MS_MIN  = 10;
  localparam int unsigned HOLD_MS_MAX  = 1200;

  // Derived cycle counts
  localparam int unsigned HOLD_CYC_MIN = HOLD_MS_MIN * CYC_PER_MS;
  localparam int unsigned HOLD_CYC_MAX = HOLD_MS_MAX * CYC_PER_MS;

  // Reset values of the outputs: the supervisor starts in reset
  localparam logic RST_LOW_INIT        = 1'b0;
  localparam logic RST_HIGH_INIT       = 1'b1;
  localparam logic RST_OD_OE_INIT      = 1'b1;
  localparam logic [7:0] EVT_CNT_INIT  = 8'h00;
  localparam logic [7:0] EVT_CNT_MAX   = 8'hff;

  // Supervisor states
  typedef enum logic [1:0] {
    SSW_RUN,
    SSW_CAUSE,
    SSW_HOLD
  } ssw_state_t;

  // Watchdog period in cycles for a selection code
  function automatic int unsigned wdt_cycles(input int unsigned sel);
    case (sel)
      0:       wdt_cycles = WDT_MS_0 * CYC_PER_MS;
      1:       wdt_cycles = WDT_MS_1 * CYC_PER_MS;
      2:       wdt_cycles = WDT_MS_2 * CYC_PER_MS;
      default: wdt_cycles = WDT_MS_3 * CYC_PER_MS;
    endcase
  endfunction

endpackage

`default_nettype wire

//--- ssw_supervisor.sv
/*
  Supply supervisor with manual reset and watchdog: one reset signal,
  offered as active-low, active-high and open-drain pins.
  Assumes all inputs are synchronous to i_clk; the supply comparator is
  an external digital undervoltage flag.
*/
// Functional notes
// - The active-low reset goes low on undervoltage, manual reset low or watchdog expiry.
// - After the supply recovers, reset stays asserted for the full hold time.
// - The active-high reset goes high on the same causes and holds for the hold time.
// - A low manual-reset input asserts reset.
// - Reset stays asserted while manual reset is low and for the hold time after it rises.
// - With the watchdog on, a kick level held longer than the expiry time expires it.
// - Watchdog expiry asserts reset for the hold time.
// - The watchdog counter clears whenever reset is asserted.
// - The watchdog counter clears on every rising or falling kick transition.
// - A low watchdog-off input enables the watchdog, a high one disables it fully.
// - The watchdog expiry time is a build-time choice of 3.3, 6, 12 or 24 seconds.
// - The reset hold time is a build-time choice between 10 ms and 1.2 s.
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor #(
  parameter int unsigned P_WDT_SEL  = 0,
  parameter int unsigned P_WDT_CYC  = ssw_pkg::wdt_cycles(P_WDT_SEL),
  parameter int unsigned P_HOLD_CYC = ssw_pkg::HOLD_CYC_MIN
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Supply and manual reset
  input  wire logic       i_supply_low,
  input  wire logic       i_manual_reset_low_in,
  // Watchdog
  input  wire logic       i_watchdog_kick_in,
  input  wire logic       i_watchdog_off_in,
  // Reset outputs
  output logic            o_sys_rst_low_out,
  output logic            o_sys_rst_high_out,
  output logic            o_sys_rst_od_oe,
  output logic            o_sys_rst_od_out,
  // Status
  output ssw_pkg::ssw_state_t o_state,
  output logic            o_cause_supply,
  output logic            o_cause_manual,
  output logic            o_cause_watchdog,
  output logic            o_wdt_expired,
  output logic            o_wdt_enabled,
  output logic [7:0]      o_event_count
);
  import ssw_pkg::*;

  // Timer limits, kept at least one cycle; expiry is strictly longer than the period
  localparam logic [CNT_W-1:0] WDT_LIMIT  = CNT_W'(P_WDT_CYC + 1);
  localparam logic [CNT_W-1:0] HOLD_LIMIT = CNT_W'((P_HOLD_CYC < 1) ? 1 : P_HOLD_CYC);

  ssw_state_t state_r;
  ssw_state_t state_nxt;

  logic wdt_en;
  logic kick_edge;
  logic mr_active;
  logic lvl_cause;
  logic wdt_fire;
  logic new_episode;

  ssw_tmr_if wdt_tmr ();
  ssw_tmr_if hold_tmr ();

  // Kick transition detector
  ssw_kick_edge u_kick (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_kick (i_watchdog_kick_in),
    .o_edge (kick_edge)
  );

  // Watchdog interval timer
  ssw_timer #(
    .P_LIMIT (WDT_LIMIT)
  ) u_wdt (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .tmr    (wdt_tmr)
  );

  // Reset hold timer
  ssw_timer #(
    .P_LIMIT (HOLD_LIMIT)
  ) u_hold (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .tmr    (hold_tmr)
  );

  // Cause decode
  assign wdt_en    = !i_watchdog_off_in;
  // A floating manual input is pulled high outside, so high means idle
  assign mr_active = !i_manual_reset_low_in;
  assign lvl_cause = i_supply_low || mr_active;

  // The timer only runs while out of reset, enabled, and no kick transition
  assign wdt_tmr.run = wdt_en && (state_r == SSW_RUN) && !kick_edge;
  assign wdt_fire    = wdt_en && wdt_tmr.done;

  // Hold interval restarts every time the hold state is entered
  assign hold_tmr.run = (state_r == SSW_HOLD) && !lvl_cause;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSW_RUN: begin
        if (lvl_cause) begin
          state_nxt = SSW_CAUSE;
        end else if (wdt_fire) begin
          state_nxt = SSW_HOLD;
        end
      end
      SSW_CAUSE: begin
        // Held for as long as any level cause is present
        if (!lvl_cause) begin
          state_nxt = SSW_HOLD;
        end
      end
      SSW_HOLD: begin
        if (lvl_cause) begin
          state_nxt = SSW_CAUSE;
        end else if (hold_tmr.done) begin
          state_nxt = SSW_RUN;
        end
      end
      default: begin
        state_nxt = SSW_HOLD;
      end
    endcase
  end

  // Power-up behaves like a supply recovery: hold first, then release
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= SSW_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reset pins, registered from the next state so they track state_r exactly
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sys_rst_low_out  <= RST_LOW_INIT;
      o_sys_rst_high_out <= RST_HIGH_INIT;
      o_sys_rst_od_oe    <= RST_OD_OE_INIT;
    end else begin
      o_sys_rst_low_out  <= (state_nxt == SSW_RUN);
      o_sys_rst_high_out <= (state_nxt != SSW_RUN);
      o_sys_rst_od_oe    <= (state_nxt != SSW_RUN);
    end
  end

  // Open-drain pin only ever drives low
  always_ff @(posedge i_clk) begin
    o_sys_rst_od_out <= 1'b0;
  end

  // State mirror
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_state <= SSW_HOLD;
    end else begin
      o_state <= state_nxt;
    end
  end

  // A fresh reset episode starts when leaving the run state
  assign new_episode = (state_r == SSW_RUN) && (state_nxt != SSW_RUN);

  // Cause flags: cleared at the start of each episode, then gathered during it,
  // so software can read why it was last reset after release
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cause_supply   <= 1'b0;
      o_cause_manual   <= 1'b0;
      o_cause_watchdog <= 1'b0;
    end else if (new_episode) begin
      o_cause_supply   <= i_supply_low;
      o_cause_manual   <= mr_active;
      o_cause_watchdog <= wdt_fire && !lvl_cause;
    end else if (state_r != SSW_RUN) begin
      o_cause_supply   <= o_cause_supply || i_supply_low;
      o_cause_manual   <= o_cause_manual || mr_active;
    end
  end

  // One-cycle expiry pulse
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wdt_expired <= 1'b0;
    end else begin
      o_wdt_expired <= (state_r == SSW_RUN) && !lvl_cause && wdt_fire;
    end
  end

  // Watchdog enable mirror
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wdt_enabled <= 1'b0;
    end else begin
      o_wdt_enabled <= wdt_en;
    end
  end

  // Saturating count of reset episodes; saturates rather than wraps so a
  // reset storm is never mistaken for a quiet system
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_event_count <= EVT_CNT_INIT;
    end else if (new_episode && (o_event_count != EVT_CNT_MAX)) begin
      o_event_count <= o_event_count + 8'h01;
    end
  end

endmodule // ssw_supervisor

`default_nettype wire

//--- ssw_supervisor_asserts.sv
/*
  Checker for the supervisor: reset causes, hold time and watchdog expiry.
  Assumes it is bound to ssw_supervisor and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor_chk
  import ssw_pkg::*;
#(
  parameter int unsigned P_WDT_CYC  = 20,
  parameter int unsigned P_HOLD_CYC = 10
) (
  // Clock and reset
  input wire logic                i_clk,
  input wire logic                i_nrst,
  // Inputs watched
  input wire logic                i_supply_low,
  input wire logic                i_manual_reset_low_in,
  input wire logic                i_watchdog_kick_in,
  input wire logic                i_watchdog_off_in,
  // Outputs watched
  input wire logic                o_sys_rst_low_out,
  input wire logic                o_sys_rst_high_out,
  input wire logic                o_sys_rst_od_oe,
  input wire ssw_pkg::ssw_state_t o_state,
  input wire logic                o_cause_watchdog,
  input wire logic                o_wdt_expired
);
  logic [31:0] hcnt_r;
  logic [31:0] kcnt_r;
  logic        kick_q_r;
  wire logic   cause_in = i_supply_low || !i_manual_reset_low_in;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // Cycles in reset with no cause at the inputs
  always_ff @(posedge i_clk) begin
    if (!i_nrst || o_sys_rst_low_out || cause_in) begin
      hcnt_r <= '0;
    end else begin
      hcnt_r <= hcnt_r + 32'h1;
    end
  end

  // Cycles of a still kick while running with the watchdog on
  always_ff @(posedge i_clk) begin
    kick_q_r <= i_watchdog_kick_in;
    if (!i_nrst || !o_sys_rst_low_out || i_watchdog_off_in
        || i_watchdog_kick_in != kick_q_r) begin
      kcnt_r <= '0;
    end else begin
      kcnt_r <= kcnt_r + 32'h1;
    end
  end

  sequence s_cause_in_hold;
    o_state == SSW_HOLD && cause_in;
  endsequence
  sequence s_back_to_cause;
    ##[1:2] o_state == SSW_CAUSE;
  endsequence

  property p_cause;
    cause_in |-> ##[1:2] !o_sys_rst_low_out;
  endproperty
  property p_inv;
    o_sys_rst_high_out != o_sys_rst_low_out && o_sys_rst_od_oe == !o_sys_rst_low_out;
  endproperty
  property p_hold_min;
    $rose(o_sys_rst_low_out) |-> hcnt_r >= P_HOLD_CYC;
  endproperty
  property p_hold_max;
    !o_sys_rst_low_out |-> hcnt_r <= P_HOLD_CYC + 2;
  endproperty
  property p_restart;
    s_cause_in_hold |-> s_back_to_cause;
  endproperty
  property p_wdt_min;
    o_wdt_expired |-> kcnt_r >= P_WDT_CYC;
  endproperty
  property p_wdt_max;
    kcnt_r <= P_WDT_CYC + 4;
  endproperty
  property p_wdt_off;
    i_watchdog_off_in [*2] |=> !o_wdt_expired;
  endproperty
  property p_wdt_rst;
    o_wdt_expired |-> !o_sys_rst_low_out && o_cause_watchdog ##1 !o_sys_rst_low_out;
  endproperty

  a_cause:    assert property (p_cause)    else $error("reset not asserted on cause");
  a_inv:      assert property (p_inv)      else $error("reset variants disagree");
  a_hold_min: assert property (p_hold_min) else $error("reset released early");
  a_hold_max: assert property (p_hold_max) else $error("reset released late");
  a_restart:  assert property (p_restart)  else $error("cause in hold ignored");
  a_wdt_min:  assert property (p_wdt_min)  else $error("watchdog expired early");
  a_wdt_max:  assert property (p_wdt_max)  else $error("watchdog expired late");
  a_wdt_off:  assert property (p_wdt_off)  else $error("watchdog fired while off");
  a_wdt_rst:  assert property (p_wdt_rst)  else $error("expiry without reset");
endmodule // ssw_supervisor_chk

bind ssw_supervisor ssw_supervisor_chk #(.P_WDT_CYC(P_WDT_CYC), .P_HOLD_CYC(P_HOLD_CYC)) i_chk (
  .i_clk, .i_nrst, .i_supply_low, .i_manual_reset_low_in, .i_watchdog_kick_in,
  .i_watchdog_off_in, .o_sys_rst_low_out, .o_sys_rst_high_out, .o_sys_rst_od_oe,
  .o_state, .o_cause_watchdog, .o_wdt_expired);

`default_nettype wire

//--- ssw_supervisor_bench.sv
/*
  Self-checking bench for the supervisor with shortened periods.
  Assumes the checker is bound in and a processor model drives the kick.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor_bench;
  import ssw_pkg::*;
  localparam int W = 20;
  localparam int H = 10;
  logic       i_clk = 0, i_nrst = 0, sup = 0, off = 0, run = 0;
  logic       man   = 1;
  logic [7:0] gap   = 8'h01;
  logic       kick, low, high, oe, od, en, xp, c_sup, c_man, c_wdt;
  logic [7:0] ec;
  ssw_state_t st;
  int         n_mismatch = 0, total_checks = 0, cyc = 0, n, k;

  always #12.5 i_clk = ~i_clk;

  ssw_supervisor #(.P_WDT_CYC(W), .P_HOLD_CYC(H)) i_ssw_supervisor (.i_clk, .i_nrst,
    .i_supply_low(sup), .i_manual_reset_low_in(man), .i_watchdog_kick_in(kick),
    .i_watchdog_off_in(off), .o_sys_rst_low_out(low), .o_sys_rst_high_out(high),
    .o_sys_rst_od_oe(oe), .o_sys_rst_od_out(od), .o_state(st), .o_cause_supply(c_sup),
    .o_cause_manual(c_man), .o_cause_watchdog(c_wdt), .o_wdt_expired(xp),
    .o_wdt_enabled(en), .o_event_count(ec));
  ssw_cpu_model i_ssw_cpu_model (.i_clk, .i_rst_low(low), .i_run(run), .i_gap(gap),
    .o_kick(kick));

  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Negedges until the reset output reaches v, capped
  task automatic meas(input logic v, output int c);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (low !== v && c < 300);
  endtask

  task automatic quiet(input int c);
    k = 0;
    repeat (c) begin
      @(negedge i_clk);
      if (low !== 1'b1) k++;
    end
  endtask

  task automatic t_supply;
    @(posedge i_clk) sup <= 1;
    repeat (4) @(negedge i_clk);
    chk("low", low, 0);
    chk("high", high, 1);
    chk("od_oe", oe, 1);
    chk("c_sup", c_sup, 1);
    chk("state", st, SSW_CAUSE);
    chk("od_out", od, 0);
    @(posedge i_clk) sup <= 0;
    meas(1, n);
    chk("hold", n >= H && n <= H + 3, 1);
    chk("high_off", high, 0);
    chk("count", ec, 8'h01);
    $display("t_supply done");
  endtask

  task automatic t_manual;
    @(posedge i_clk) man <= 0;
    repeat (4) @(negedge i_clk);
    chk("low", low, 0);
    chk("c_man", c_man, 1);
    chk("c_sup_clr", c_sup, 0);
    @(posedge i_clk) man <= 1;
    repeat (H - 4) @(negedge i_clk);
    chk("held", low, 0);
    @(posedge i_clk) man <= 0;
    @(posedge i_clk) man <= 1;
    meas(1, n);
    chk("restart", n >= H && n <= H + 3, 1);
    // A cause returning inside the hold is the same episode
    chk("count", ec, 8'h02);
    $display("t_manual done");
  endtask

  task automatic t_wdt;
    @(posedge i_clk);
    gap <= 8'(W - 1);
    run <= 1;
    quiet(6 * W);
    chk("kicked", k, 0);
    @(posedge i_clk) gap <= 8'h01;
    repeat (4) @(negedge i_clk);
    @(posedge i_clk) run <= 0;
    meas(0, n);
    chk("expiry", n >= W - 1 && n <= W + 4, 1);
    chk("expired", xp, 1);
    chk("c_wdt", c_wdt, 1);
    chk("c_man_clr", c_man, 0);
    meas(1, n);
    chk("wdt_hold", n >= H - 1 && n <= H + 3, 1);
    meas(0, n);
    chk("cleared", n >= W && n <= W + 4, 1);
    meas(1, n);
    chk("count", ec, 8'h04);
    $display("t_wdt done");
  endtask

  task automatic t_off;
    @(posedge i_clk) off <= 1;
    quiet(4 * W);
    chk("off", k, 0);
    chk("wdt_en", en, 0);
    @(posedge i_clk) off <= 0;
    meas(0, n);
    chk("on", n >= W && n <= W + 5, 1);
    chk("wdt_en_on", en, 1);
    chk("expired", xp, 1);
    meas(1, n);
    chk("count", ec, 8'h05);
    $display("t_off done");
  endtask

  // Releases reset on the next edge and times the power-up hold
  task automatic t_power;
    @(posedge i_clk) i_nrst <= 1;
    meas(1, n);
    chk("power_hold", n >= H && n <= H + 3, 1);
    chk("state", st, SSW_RUN);
    $display("t_power done");
  endtask

  // Build-time options at the real 40 MHz clock
  task automatic t_sel;
    chk("wdt_sel0", wdt_cycles(0), 32'h07de2900);
    chk("wdt_sel1", wdt_cycles(1), 32'h0e4e1c00);
    chk("wdt_sel2", wdt_cycles(2), 32'h1c9c3800);
    chk("wdt_sel3", wdt_cycles(3), 32'h39387000);
    chk("hold_min", HOLD_CYC_MIN, 32'h00061a80);
    chk("hold_max", HOLD_CYC_MAX, 32'h02dc6c00);
    $display("t_sel done");
  endtask

  // Reset in mid-run must pull the output low and restart the full hold
  task automatic t_rst;
    @(posedge i_clk) i_nrst <= 0;
    repeat (2) @(negedge i_clk);
    chk("rst_low", low, 0);
    chk("rst_high", high, 1);
    t_power;
    $display("t_rst done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole run is under a thousand cycles; this cuts a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      results;
    end
  end

  initial begin
    // The twelfth edge is taken inside t_power
    repeat (11) @(posedge i_clk);
    t_power;
    t_sel;
    t_supply;
    t_manual;
    t_wdt;
    t_off;
    t_rst;
    results;
  end
endmodule // ssw_supervisor_bench

`default_nettype wire

//--- ssw_timer.sv
/*
  Interval timer: counts while run is high, clears when run is low,
  and flags done once it has run for P_LIMIT cycles.
  Assumes the owner drops run to restart the interval.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_timer #(
  parameter logic [ssw_pkg::CNT_W-1:0] P_LIMIT = 30'h1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Handshake
  ssw_tmr_if.timer  tmr
);
  import ssw_pkg::*;

  logic [CNT_W-1:0] cnt_r;

  // Stops at the limit so done stays up until the owner reacts
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_r <= '0;
    end else if (!tmr.run) begin
      cnt_r <= '0;
    end else if (cnt_r != P_LIMIT - 30'h1) begin
      cnt_r <= cnt_r + 30'h1;
    end
  end

  assign tmr.done = tmr.run && (cnt_r == P_LIMIT - 30'h1);

endmodule // ssw_timer

`default_nettype wire

//--- ssw_tmr_if.sv
/*
  Run and done handshake between the supervisor and one interval timer.
  Assumes both ends share the supervisor clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface ssw_tmr_if;
  logic run;
  logic done;

  modport owner (output run, input  done);
  modport timer (input  run, output done);
endinterface

`default_nettype wire
